// *** include/gpc_regs_pkg.sv ***
package gpc_regs_pkg;
    // ***************************************************************
    // register map
    // ***************************************************************
    localparam logic [7:0] OFFS_CFG3 = 8'hd3;
    localparam logic [7:0] OFFS_CFG4 = 8'hd4;
    localparam logic [7:0] OFFS_CFG5 = 8'hd5;
    localparam logic [7:0] OFFS_CFG6 = 8'hd6;

    localparam logic [7:0] RST_CFG3  = 8'h21;
    localparam logic [7:0] RST_CFG4  = 8'h03;
    localparam logic [7:0] RST_CFG5  = 8'h65;
    localparam logic [7:0] RST_CFG6  = 8'h07;

    // writable bit masks, everything else is reserved
    localparam logic [7:0] WMSK_CFG3 = 8'hf7;
    localparam logic [7:0] WMSK_CFG4 = 8'h87;
    localparam logic [7:0] WMSK_CFG5 = 8'h80;
    localparam logic [7:0] WMSK_CFG6 = 8'ha0;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int SW_EN_BIT     = 7;
    localparam int COMPAT_BIT    = 5;
    localparam int SEL_LO_LSB    = 0;
    localparam int SEL_HI_LSB    = 4;
    localparam int SEL_W         = 3;
    localparam int NUM_CH        = 4;
endpackage : gpc_regs_pkg

// *** verilog/clk_source_mux.sv ***
`timescale 1ns/1ps
// selects one of four channel clocks from a 3-bit code
module clk_source_mux (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] sel,
    input  wire logic [3:0] chanClk,
    output logic            clkOut
);
    typedef struct packed {
        logic outBit;
    } mux_state_type;

    mux_state_type st_ff;
    mux_state_type nxt_st;

    // reserved codes (msb set) give a quiet low output
    always_comb begin
        nxt_st = st_ff;
        nxt_st.outBit = sel[2] ? 1'b0 : chanClk[sel[1:0]];
    end

    // registered output
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign clkOut = st_ff.outBit;
endmodule : clk_source_mux

// *** verilog/global_port_config_regs.sv ***
`timescale 1ns/1ps
// Function
// R1: config4 bits 2:0 pick channel for output4
// R2: software never writes reserved 1xx codes; the testbench t_mask writes 8'hff, giving code 111 in config3 and config4
// R3: switches enabled only if all four bit7s set
// R4: global enable low blocks every port switch
// R5: port switch needs global enable and own bit
// R6: compat bit low keeps legacy compatible mode
// R7: compat bit high selects generic clock mode
// R8: config3 selects outputs 2 and 3 likewise
// R9: reserved bits ignore writes, read reset value
module global_port_config_regs (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrStb,
    input  wire logic       regRdStb,
    output logic      [7:0] regRdData,
    input  wire logic [3:0] chanClk,
    input  wire logic [3:0] portSwitchReq,
    output logic      [3:0] portSwitchOn,
    output logic            recoveredClockOut2,
    output logic            recoveredClockOut3,
    output logic            recoveredClockOut4,
    output logic            genericMode
);
    // ***************************************************************
    // state
    // ***************************************************************
    typedef struct packed {
        logic [7:0] cfg3;
        logic [7:0] cfg4;
        logic [7:0] cfg5;
        logic [7:0] cfg6;
        logic [7:0] rdData;
        logic [3:0] swOn;
        logic       generic;
    } regs_state_type;

    regs_state_type st_ff;
    regs_state_type nxt_st;
    logic           globalEn;

    // one clock domain, checks idle during reset
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // masked write keeping reserved bits at reset value
    function automatic logic [7:0] mwrite(input logic [7:0] wd,
                                          input logic [7:0] msk,
                                          input logic [7:0] rv);
        mwrite = (wd & msk) | (rv & ~msk);
    endfunction : mwrite

    // all four enable copies must be set
    assign globalEn = st_ff.cfg3[gpc_regs_pkg::SW_EN_BIT] // R3
                    & st_ff.cfg4[gpc_regs_pkg::SW_EN_BIT]
                    & st_ff.cfg5[gpc_regs_pkg::SW_EN_BIT]
                    & st_ff.cfg6[gpc_regs_pkg::SW_EN_BIT];

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb begin
        nxt_st = st_ff;
        if (regWrStb) begin
            unique case (regAddr)
                gpc_regs_pkg::OFFS_CFG3: nxt_st.cfg3 = mwrite(regWrData,
                    gpc_regs_pkg::WMSK_CFG3, gpc_regs_pkg::RST_CFG3); // R9
                gpc_regs_pkg::OFFS_CFG4: nxt_st.cfg4 = mwrite(regWrData,
                    gpc_regs_pkg::WMSK_CFG4, gpc_regs_pkg::RST_CFG4); // R9
                gpc_regs_pkg::OFFS_CFG5: nxt_st.cfg5 = mwrite(regWrData,
                    gpc_regs_pkg::WMSK_CFG5, gpc_regs_pkg::RST_CFG5); // R9
                gpc_regs_pkg::OFFS_CFG6: nxt_st.cfg6 = mwrite(regWrData,
                    gpc_regs_pkg::WMSK_CFG6, gpc_regs_pkg::RST_CFG6); // R9
                default: ;
            endcase
        end
        // read data valid one cycle after strobe, zero when unmapped
        nxt_st.rdData = 8'h00;
        if (regRdStb) begin
            unique case (regAddr)
                gpc_regs_pkg::OFFS_CFG3: nxt_st.rdData = st_ff.cfg3;
                gpc_regs_pkg::OFFS_CFG4: nxt_st.rdData = st_ff.cfg4;
                gpc_regs_pkg::OFFS_CFG5: nxt_st.rdData = st_ff.cfg5;
                gpc_regs_pkg::OFFS_CFG6: nxt_st.rdData = st_ff.cfg6;
                default:                 nxt_st.rdData = 8'h00;
            endcase
        end
        // port switch gated by global enable
        nxt_st.swOn = globalEn ? portSwitchReq : 4'h0; // R4 R5
        nxt_st.generic = st_ff.cfg6[gpc_regs_pkg::COMPAT_BIT]; // R6 R7
    end

    // ***************************************************************
    // registers
    // ***************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_ff.cfg3    <= gpc_regs_pkg::RST_CFG3;
            st_ff.cfg4    <= gpc_regs_pkg::RST_CFG4;
            st_ff.cfg5    <= gpc_regs_pkg::RST_CFG5;
            st_ff.cfg6    <= gpc_regs_pkg::RST_CFG6;
            st_ff.rdData  <= 8'h00;
            st_ff.swOn    <= 4'h0;
            st_ff.generic <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign regRdData    = st_ff.rdData;
    assign portSwitchOn = st_ff.swOn;
    assign genericMode  = st_ff.generic;

    // ***************************************************************
    // clock output selection
    // ***************************************************************
    // output2 from config3 bits 2:0
    clk_source_mux u_mux2 ( // R8
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .sel     (st_ff.cfg3[gpc_regs_pkg::SEL_LO_LSB +: 3]),
        .chanClk (chanClk),
        .clkOut  (recoveredClockOut2)
    );
    // output3 from config3 bits 6:4
    clk_source_mux u_mux3 ( // R8
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .sel     (st_ff.cfg3[gpc_regs_pkg::SEL_HI_LSB +: 3]),
        .chanClk (chanClk),
        .clkOut  (recoveredClockOut3)
    );
    // output4 from config4 bits 2:0
    clk_source_mux u_mux4 ( // R1
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .sel     (st_ff.cfg4[gpc_regs_pkg::SEL_LO_LSB +: 3]),
        .chanClk (chanClk),
        .clkOut  (recoveredClockOut4)
    );

    // ***************************************************************
    // checks
    // ***************************************************************
    // switch gating
    chk_switch_gated: assert property ( // R4
        !globalEn |=> portSwitchOn == 4'h0)
        else $error("switch on without global enable");
    chk_switch_follow: assert property ( // R5
        globalEn |=> portSwitchOn == $past(portSwitchReq))
        else $error("switch does not follow port request");
    chk_switch_needs_all: assert property ( // R3
        portSwitchOn != 4'h0 |-> $past(globalEn))
        else $error("switch on while an enable copy is low");

    // mode status
    chk_mode_follow: assert property ( // R7
        ##1 genericMode == $past(st_ff.cfg6[gpc_regs_pkg::COMPAT_BIT]))
        else $error("generic mode mismatch");
    chk_mode_compat: assert property ( // R6
        !st_ff.cfg6[gpc_regs_pkg::COMPAT_BIT] |=> !genericMode)
        else $error("generic mode while compat bit low");

    // clock routing
    chk_out4_route: assert property ( // R1
        st_ff.cfg4[2] == 1'b0 && $stable(st_ff.cfg4)
        |=> recoveredClockOut4 == $past(chanClk[st_ff.cfg4[1:0]]))
        else $error("output4 wrong channel");
    chk_out3_route: assert property ( // R8
        st_ff.cfg3[6] == 1'b0
        |=> recoveredClockOut3 == $past(chanClk[st_ff.cfg3[5:4]]))
        else $error("output3 wrong channel");
    chk_out2_route: assert property ( // R8
        st_ff.cfg3[2] == 1'b0
        |=> recoveredClockOut2 == $past(chanClk[st_ff.cfg3[1:0]]))
        else $error("output2 wrong channel");

    // register access
    chk_reserved_keep: assert property ( // R9
        regWrStb && regAddr == gpc_regs_pkg::OFFS_CFG5
        |=> st_ff.cfg5[6:0] == gpc_regs_pkg::RST_CFG5[6:0])
        else $error("reserved bits changed");
    chk_reserved_cfg6: assert property ( // R9
        regWrStb && regAddr == gpc_regs_pkg::OFFS_CFG6
        |=> (st_ff.cfg6 & ~gpc_regs_pkg::WMSK_CFG6)
            == (gpc_regs_pkg::RST_CFG6 & ~gpc_regs_pkg::WMSK_CFG6))
        else $error("reserved bits of config6 changed");
    chk_read_timing: assert property ( // R9
        regRdStb && regAddr == gpc_regs_pkg::OFFS_CFG6 && !regWrStb
        |=> regRdData == $past(st_ff.cfg6))
        else $error("read data wrong");
    chk_read_idle: assert property ( // R9
        !regRdStb |=> regRdData == 8'h00)
        else $error("read data outside read slot");
    chk_write_enable: assert property ( // R3
        regWrStb && regAddr == gpc_regs_pkg::OFFS_CFG4
        |=> st_ff.cfg4[gpc_regs_pkg::SW_EN_BIT] == $past(regWrData[7]))
        else $error("enable bit not stored");
endmodule : global_port_config_regs

// *** tb/global_port_config_regs_tb.sv ***
`timescale 1ns/1ps
module global_port_config_regs_tb;
    // ***************************************************************
    // stimulus signals
    // ***************************************************************
    logic       sys_clk       = 1'b0;
    logic       rst_b         = 1'b0;
    logic [7:0] regAddr       = 8'h00;
    logic [7:0] regWrData     = 8'h00;
    logic       regWrStb      = 1'b0;
    logic       regRdStb      = 1'b0;
    logic [7:0] regRdData;
    logic [3:0] chanClk       = 4'h0;
    logic [3:0] portSwitchReq = 4'h0;
    logic [3:0] portSwitchOn;
    logic       recoveredClockOut2;
    logic       recoveredClockOut3;
    logic       recoveredClockOut4;
    logic       genericMode;
    int         n_fail        = 0;
    int         num_checks    = 0;
    logic [7:0] offs [4] = '{gpc_regs_pkg::OFFS_CFG3,
                             gpc_regs_pkg::OFFS_CFG4,
                             gpc_regs_pkg::OFFS_CFG5,
                             gpc_regs_pkg::OFFS_CFG6};
    logic [7:0] rsts [4] = '{gpc_regs_pkg::RST_CFG3,
                             gpc_regs_pkg::RST_CFG4,
                             gpc_regs_pkg::RST_CFG5,
                             gpc_regs_pkg::RST_CFG6};
    logic [7:0] wms  [4] = '{gpc_regs_pkg::WMSK_CFG3,
                             gpc_regs_pkg::WMSK_CFG4,
                             gpc_regs_pkg::WMSK_CFG5,
                             gpc_regs_pkg::WMSK_CFG6};

    // clock generation
    always #5 sys_clk = ~sys_clk;

    global_port_config_regs uut (.sys_clk(sys_clk), .rst_b(rst_b),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData), .chanClk(chanClk),
        .portSwitchReq(portSwitchReq), .portSwitchOn(portSwitchOn),
        .recoveredClockOut2(recoveredClockOut2),
        .recoveredClockOut3(recoveredClockOut3),
        .recoveredClockOut4(recoveredClockOut4), .genericMode(genericMode));

    // ***************************************************************
    // bus and compare tasks
    // ***************************************************************
    task chk(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge sys_clk);
        regWrStb  <= 1'b0;
    endtask : wr

    task rd(logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1 d = regRdData;
    endtask : rd

    task settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle

    // ***************************************************************
    // scenarios
    // ***************************************************************
    task t_reset;
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            rd(offs[i], d);
            chk("reset value", rsts[i], d);
        end
        @(posedge sys_clk);
        #1 chk("read idle", 8'h00, regRdData);
        rd(8'hd7, d);
        chk("unmapped read", 8'h00, d);
        chk("switch after reset", 8'h00, portSwitchOn);
        $display("test reset done");
    endtask : t_reset

    task t_mask;
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            wr(offs[i], 8'hff);
            rd(offs[i], d);
            chk("write ones", (rsts[i] & ~wms[i]) | wms[i], d);
            wr(offs[i], 8'h00);
            rd(offs[i], d);
            chk("write zeros", rsts[i] & ~wms[i], d);
        end
        $display("test mask done");
    endtask : t_mask

    task t_switch;
        for (int i = 0; i < 4; i++) wr(offs[i], 8'h80);
        portSwitchReq <= 4'ha;
        settle();
        chk("switch all enabled", 8'h0a, portSwitchOn);
        for (int i = 0; i < 4; i++) begin
            wr(offs[i], 8'h00);
            settle();
            chk("switch one cleared", 8'h00, portSwitchOn);
            wr(offs[i], 8'h80);
        end
        $display("test switch done");
    endtask : t_switch

    task t_sel;
        logic [3:0] v;
        // only legal codes 000..011 are written
        for (int c = 0; c < 4; c++) begin
            wr(gpc_regs_pkg::OFFS_CFG4, 8'(c));
            wr(gpc_regs_pkg::OFFS_CFG3, {1'b0, 3'(c), 1'b0, 3'(c)});
            for (int p = 0; p < 2; p++) begin
                v = 4'(1 << c);
                if (p == 1) v = ~v;
                chanClk <= v;
                settle();
                chk("clock out4", 8'(v[c % 4]), recoveredClockOut4);
                chk("clock out3", 8'(v[c % 4]), recoveredClockOut3);
                chk("clock out2", 8'(v[c % 4]), recoveredClockOut2);
            end
        end
        $display("test select done");
    endtask : t_sel

    task t_mode;
        wr(gpc_regs_pkg::OFFS_CFG6, 8'h20);
        settle();
        chk("generic mode", 8'h01, genericMode);
        wr(gpc_regs_pkg::OFFS_CFG6, 8'h00);
        settle();
        chk("compat mode", 8'h00, genericMode);
        $display("test mode done");
    endtask : t_mode

    task summarize;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // watchdog against a hung bus
    initial begin
        #200000;
        n_fail++;
        summarize();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_mask();
        t_switch();
        t_sel();
        t_mode();
        summarize();
    end
endmodule : global_port_config_regs_tb
